//--- src/imr_params.svh
// Offsets, field positions, reset values and bit counts of the receive block.
// Assumes nothing; included by bare name from the design files.
`ifndef IMR_PARAMS_SVH
`define IMR_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define IMR_OFF_CTRL 4'h0
`define IMR_OFF_DATA 4'h4
`define IMR_OFF_STAT 4'h8
`define IMR_OFF_BAUD 4'hC

// Field positions in port_control_two.
`define IMR_CTRL_SEN 0
`define IMR_CTRL_MASTER_RECEIVE_REQUEST 3
`define IMR_CTRL_ACK_SEQUENCE_REQUEST 4
`define IMR_CTRL_ACK_VALUE_SELECT 5
`define IMR_CTRL_ACKST 6

// Field positions in the status register.
`define IMR_STAT_BF 0
`define IMR_STAT_IRQ 1
`define IMR_STAT_OV 2
`define IMR_STAT_WRITE_COLLISION_FLAG 3
`define IMR_STAT_IDLE 4

// Reset reload of the baud generator: half period is reload plus one.
`define IMR_BAUD_RST 8'h63

// Bus responses.
`define IMR_RESP_OK 2'h0
`define IMR_RESP_ERR 2'h2

// Bit slots of a byte transfer and the last step of a start condition.
`define IMR_LAST_BIT 4'h7
`define IMR_ACK_BIT 4'h8
`define IMR_START_END 4'h2

`endif

//--- src/imr_pkg.sv
// Types shared by the receive block and its baud generator.
// Assumes nothing of its surroundings.
package imr_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    IMR_IDLE = 5'b00001,
    IMR_START = 5'b00010,
    IMR_ADDR = 5'b00100,
    IMR_RECV = 5'b01000,
    IMR_ACK = 5'b10000
  } imr_state_t;

  // Control bits seen by software.
  typedef struct packed {
    logic start_condition_request;
    logic master_receive_request;
    logic ack_sequence_request;
    logic ack_value_select;
    logic ack_received_status;
  } imr_ctrl_t;

  // Sticky status flags.
  typedef struct packed {
    logic bf;
    logic irq;
    logic ov;
    logic write_collision_flag;
  } imr_flags_t;

  // Whole state of the top module.
  typedef struct packed {
    imr_state_t st;
    imr_ctrl_t ctrl;
    imr_flags_t fl;
    logic [7:0] buf_q;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic [7:0] baud;
    logic scl_oe;
    logic sda_oe;
    logic aw_have;
    logic [3:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } imr_regs_t;

  // State of the baud generator.
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } imr_brg_t;

endpackage

//--- src/imr_brg.sv
// Baud rate generator: one-cycle tick every reload plus one cycles.
// Assumes the caller holds run low while the serial port is idle.
`timescale 1ns/1ps
`default_nettype none
module imr_brg
  import imr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // Control.
  input wire logic run,
  input wire logic [7:0] reload,
  // Half-period tick.
  output logic tick
);

  imr_brg_t r;
  imr_brg_t n;

  // Count down while running; a stopped generator stays at reload so the
  // first half period after a start is always a full one.
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = reload;
    end else if (r.cnt == 8'h00) begin
      n.cnt = reload;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt - 8'h01;
    end
  end

  // State register.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule
`default_nettype wire

//--- src/imr_top.sv
// I2C master receive path with AXI4-Lite registers and open-drain pins.
// Assumes the bus lines are resolved outside and inputs are synchronous.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "imr_params.svh"

// What this block does
// - A receive request written while the port is busy is ignored.
// - In a received byte, each baud rollover toggles the clock line; every second one shifts in a data bit.
// - After the eighth fall: clear request, load buffer, set flags, hold clock.
// - After delivery the port idles until software gives the next command.
// - Reading the data buffer clears the buffer-full flag.
// - Every byte loaded into the data buffer sets buffer-full.
// - A byte arriving while buffer-full is set raises overflow.
// - A data write during a transfer sets collision and changes nothing.
// - A start request produces a start condition, then the interrupt flag.
// - Writing the address byte sends all eight bits in turn, MSB first.
// - The slave acknowledge after the address is stored in a status bit.
// - The interrupt flag is set at the end of the ninth address clock.
// - The chosen acknowledge is clocked out, then the interrupt flag set.
// - Acknowledge is low in the ninth slot; the sender releases the line.
module imr_top
  import imr_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SRST,
  // AXI4-Lite write channels.
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels.
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Serial clock line, open drain.
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  // Serial data line, open drain.
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  imr_regs_t r;
  imr_regs_t n;
  logic tick;
  logic hi_tick;
  logic wr_go;
  logic rd_go;
  logic [3:0] wr_off;
  logic [3:0] rd_off;
  logic lane0;
  logic rx_end;
  logic addr_end;
  logic start_end;
  logic ack_end;
  logic is_idle;

  // ---------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------

  // Suspended while idle, which leaves the clock line where it was.
  imr_brg u_brg (
    .CLK(CLK),
    .SRST(SRST),
    .run(r.st != IMR_IDLE),
    .reload(r.baud),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------

  // A write is performed once address and data are both held.
  assign is_idle = (r.st == IMR_IDLE);
  assign hi_tick = tick && !r.scl_oe;
  assign wr_go = r.aw_have && r.w_have && !r.bvalid;
  assign wr_off = {r.awaddr[3:2], 2'b00};
  assign lane0 = r.wstrb[0];
  assign rd_go = S_AXI_ARVALID && r.ar_rdy;
  assign rd_off = {S_AXI_ARADDR[3:2], 2'b00};
  assign start_end = (r.st == IMR_START) && tick &&
                     (r.bitn == `IMR_START_END);
  assign addr_end = (r.st == IMR_ADDR) && hi_tick &&
                    (r.bitn == `IMR_ACK_BIT);
  assign rx_end = (r.st == IMR_RECV) && hi_tick &&
                  (r.bitn == `IMR_LAST_BIT);
  assign ack_end = (r.st == IMR_ACK) && hi_tick;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Bus effects come first and the sequencer last, so a flag that the
  // sequencer sets in the same cycle that software clears it survives.
  always_comb begin
    n = r;
    // Write channel capture.
    if (S_AXI_AWVALID && r.aw_rdy) begin
      n.aw_have = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r.w_rdy) begin
      n.w_have = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (r.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    // Read channel.
    if (r.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp = `IMR_RESP_OK;
      n.rdata = 32'h0000_0000;
      case (rd_off)
        `IMR_OFF_CTRL: begin
          n.rdata[`IMR_CTRL_SEN] = r.ctrl.start_condition_request;
          n.rdata[`IMR_CTRL_MASTER_RECEIVE_REQUEST] = r.ctrl.master_receive_request;
          n.rdata[`IMR_CTRL_ACK_SEQUENCE_REQUEST] = r.ctrl.ack_sequence_request;
          n.rdata[`IMR_CTRL_ACK_VALUE_SELECT] = r.ctrl.ack_value_select;
          n.rdata[`IMR_CTRL_ACKST] = r.ctrl.ack_received_status;
        end
        `IMR_OFF_DATA: begin
          n.rdata[7:0] = r.buf_q;
          n.fl.bf = 1'b0;
        end
        `IMR_OFF_STAT: begin
          n.rdata[`IMR_STAT_BF] = r.fl.bf;
          n.rdata[`IMR_STAT_IRQ] = r.fl.irq;
          n.rdata[`IMR_STAT_OV] = r.fl.ov;
          n.rdata[`IMR_STAT_WRITE_COLLISION_FLAG] = r.fl.write_collision_flag;
          n.rdata[`IMR_STAT_IDLE] = is_idle;
        end
        `IMR_OFF_BAUD: n.rdata[7:0] = r.baud;
        default: n.rresp = `IMR_RESP_ERR;
      endcase
    end
    // Register writes; only byte lane 0 carries register bits.
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `IMR_RESP_OK;
      case (wr_off)
        `IMR_OFF_CTRL: if (lane0) begin
          n.ctrl.ack_value_select = r.wdata[`IMR_CTRL_ACK_VALUE_SELECT];
          // Commands are taken only from idle; the rest are dropped.
          if (is_idle) begin
            if (r.wdata[`IMR_CTRL_SEN]) begin
              n.ctrl.start_condition_request = 1'b1;
              n.st = IMR_START;
              n.bitn = 4'h0;
            end else if (r.wdata[`IMR_CTRL_MASTER_RECEIVE_REQUEST]) begin
              n.ctrl.master_receive_request = 1'b1;
              n.st = IMR_RECV;
              n.bitn = 4'h0;
              n.sda_oe = 1'b0;
            end else if (r.wdata[`IMR_CTRL_ACK_SEQUENCE_REQUEST]) begin
              n.ctrl.ack_sequence_request = 1'b1;
              n.st = IMR_ACK;
              n.sda_oe = !r.wdata[`IMR_CTRL_ACK_VALUE_SELECT];
            end
          end
        end
        `IMR_OFF_DATA: if (lane0) begin
          if (!is_idle) begin
            n.fl.write_collision_flag = 1'b1;
          end else begin
            // Address goes out at once, MSB first.
            n.st = IMR_ADDR;
            n.shreg = r.wdata[7:0];
            n.bitn = 4'h0;
            n.sda_oe = !r.wdata[7];
          end
        end
        `IMR_OFF_STAT: if (lane0) begin
          // Write one to clear.
          if (r.wdata[`IMR_STAT_IRQ]) n.fl.irq = 1'b0;
          if (r.wdata[`IMR_STAT_OV]) n.fl.ov = 1'b0;
          if (r.wdata[`IMR_STAT_WRITE_COLLISION_FLAG]) n.fl.write_collision_flag = 1'b0;
        end
        `IMR_OFF_BAUD: if (lane0) n.baud = r.wdata[7:0];
        default: n.bresp = `IMR_RESP_ERR;
      endcase
    end
    // Serial sequencer: low phase ends by releasing the clock, high phase
    // ends by pulling the clock low again, after sampling in receive and in the ninth address slot.
    case (r.st)
      IMR_IDLE: begin
      end
      IMR_START: if (tick) begin
        n.bitn = r.bitn + 4'h1;
        case (r.bitn)
          4'h0: begin
            n.scl_oe = 1'b0;
            n.sda_oe = 1'b0;
          end
          4'h1: n.sda_oe = 1'b1;
          default: begin
            n.scl_oe = 1'b1;
            n.ctrl.start_condition_request = 1'b0;
            n.fl.irq = 1'b1;
            n.st = IMR_IDLE;
          end
        endcase
      end
      IMR_ADDR: if (tick) begin
        n.scl_oe = !r.scl_oe;
        if (hi_tick) begin
          if (r.bitn == `IMR_ACK_BIT) begin
            n.ctrl.ack_received_status = SDA_I;
            n.fl.irq = 1'b1;
            n.st = IMR_IDLE;
          end else begin
            n.bitn = r.bitn + 4'h1;
            n.shreg = {r.shreg[6:0], 1'b0};
            // Release the line for the slave's acknowledge slot.
            if (r.bitn == `IMR_LAST_BIT) n.sda_oe = 1'b0;
            else n.sda_oe = !r.shreg[6];
          end
        end
      end
      IMR_RECV: if (tick) begin
        n.scl_oe = !r.scl_oe;
        if (hi_tick) begin
          n.shreg = {r.shreg[6:0], SDA_I};
          n.bitn = r.bitn + 4'h1;
          if (r.bitn == `IMR_LAST_BIT) begin
            n.ctrl.master_receive_request = 1'b0;
            n.buf_q = {r.shreg[6:0], SDA_I};
            n.fl.bf = 1'b1;
            if (r.fl.bf) n.fl.ov = 1'b1;
            n.fl.irq = 1'b1;
            n.st = IMR_IDLE;
          end
        end
      end
      IMR_ACK: if (tick) begin
        n.scl_oe = !r.scl_oe;
        if (hi_tick) begin
          n.ctrl.ack_sequence_request = 1'b0;
          n.fl.irq = 1'b1;
          n.st = IMR_IDLE;
        end
      end
      default: n.st = IMR_IDLE;
    endcase
    // Ready is offered only while nothing is held for that channel.
    n.aw_rdy = !n.aw_have && !n.bvalid;
    n.w_rdy = !n.w_have && !n.bvalid;
    n.ar_rdy = !n.rvalid;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------

  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
      r.st <= IMR_IDLE;
      r.baud <= `IMR_BAUD_RST;
    end else begin
      r <= n;
    end
  end

  // Open drain: the pad only ever pulls low, so the data outputs stay 0.
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = r.scl_oe;
  assign SDA_OE = r.sda_oe;
  assign S_AXI_AWREADY = r.aw_rdy;
  assign S_AXI_WREADY = r.w_rdy;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = r.ar_rdy;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RRESP = r.rresp;
  assign S_AXI_RDATA = r.rdata;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  sequence s_rx_last;
    rx_end;
  endsequence

  sequence s_delivered;
    r.fl.bf && r.scl_oe && !r.ctrl.master_receive_request && (r.buf_q == $past(n.buf_q));
  endsequence

  a_rx_deliver: assert property (s_rx_last |=> s_delivered)
    else $error("received byte not delivered");
  a_idle_hold: assert property ((is_idle && !wr_go) |=> is_idle)
    else $error("bus action without a command");
  a_rcv_gate: assert property ($rose(r.st == IMR_RECV) |->
    $past(is_idle))
    else $error("receive started while busy");
  a_scl_toggle: assert property (
    (tick && !is_idle && r.st != IMR_START) |=>
    r.scl_oe != $past(r.scl_oe))
    else $error("clock line did not toggle");
  a_bf_clear: assert property ((rd_go && rd_off == `IMR_OFF_DATA &&
    !rx_end) |=> !r.fl.bf)
    else $error("buffer full not cleared by read");
  a_ov_set: assert property ((rx_end && r.fl.bf) |=> r.fl.ov)
    else $error("overflow missed");
  a_write_collision_flag_set: assert property ((wr_go && wr_off == `IMR_OFF_DATA &&
    lane0 && !is_idle) |=> r.fl.write_collision_flag && $stable(r.buf_q))
    else $error("write collision missed");
  a_start_done: assert property (start_end |=>
    r.fl.irq && r.scl_oe && r.sda_oe && is_idle)
    else $error("start condition incomplete");
  a_addr_bit: assert property ((r.st == IMR_ADDR && r.bitn < 4'h8)
    |-> r.sda_oe == !r.shreg[7])
    else $error("address bit wrong on data line");
  a_ack_stat: assert property (addr_end |=>
    r.ctrl.ack_received_status == $past(SDA_I) && r.fl.irq)
    else $error("acknowledge status not stored");
  a_ack_drive: assert property (
    ((r.st == IMR_ACK) |-> r.sda_oe == !r.ctrl.ack_value_select) and
    (ack_end |=> r.fl.irq))
    else $error("acknowledge level wrong");

endmodule
`default_nettype wire

//--- dv/imr_slave_model.sv
// Behavioural I2C slave that answers a read with an incrementing byte.
// Assumes resolved open-drain line levels with pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
module imr_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] FIRST = 8'hC5
) (
  // Resolved bus lines.
  input wire logic scl,
  input wire logic sda,
  // Data line pull-down and observations.
  output logic sda_oe,
  output logic [7:0] got_addr,
  output logic m_ack,
  output int edges
);
  int ph;
  int cnt;
  logic [7:0] sh;
  logic [7:0] dat;
  logic hit;

  initial begin
    sda_oe = 0; ph = 0; cnt = 0; edges = 0; got_addr = 0;
    m_ack = 1; sh = 0; dat = FIRST; hit = 0;
  end

  // A falling data line while the clock is high restarts the frame.
  // The master may move both lines in one time step, so the clock is
  // judged a moment later to avoid a false start on a data change.
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) begin
      ph = 1; cnt = 0; sda_oe = 0; dat = FIRST;
    end
  end

  // Sample on rising clock; the ninth slot of a data byte is the master's.
  always @(posedge scl) begin
    edges++;
    if (ph == 1 && cnt < 8) sh = {sh[6:0], sda};
    if (ph == 3) m_ack = sda;
    cnt++;
  end

  // Change the data line only while the clock is low.
  always @(negedge scl) begin
    if (ph == 1 && cnt == 8) begin
      got_addr = sh;
      hit = (sh[7:1] == ADDR);
      sda_oe = hit;
    end else if (ph == 1 && cnt == 9) begin
      if (hit && sh[0]) begin
        ph = 2; cnt = 0; sda_oe = ~dat[7];
      end else begin
        ph = 0; sda_oe = 0;
      end
    end else if (ph == 2 && cnt == 8) begin
      ph = 3; sda_oe = 0;
    end else if (ph == 2) begin
      sda_oe = ~dat[7 - cnt];
    end else if (ph == 3) begin
      // A real slave lets go after a not-acknowledge.
      if (!m_ack) begin
        ph = 2; cnt = 0; dat = dat + 1; sda_oe = ~dat[7];
      end else begin
        ph = 0; sda_oe = 0;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/imr_top_tb.sv
// Self-checking bench for the receive block over AXI4-Lite.
// Assumes the slave model on the far side and pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
`include "imr_params.svh"
module imr_top_tb;
  logic clk = 0, srst = 1;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic scl_o, scl_oe, sda_o, sda_oe, s_oe, m_ack;
  wire logic scl, sda;
  logic [7:0] got_addr;
  int edges, err_count = 0, n_checks = 0;

  // Open-drain resolution with pull-ups.
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_oe && !sda_o) || s_oe);

  always #12.5 clk = ~clk;

  imr_top u_dut (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SCL_I(scl),
    .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE(sda_oe));

  imr_slave_model u_slave (.scl(scl), .sda(sda), .sda_oe(s_oe),
    .got_addr(got_addr), .m_ack(m_ack), .edges(edges));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Handshakes are judged on values settled before the edge.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, wd, ah, wh, bh;
    ad = 0; wd = 0; bh = 0;
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge clk);
      if (ah) begin
        awvalid <= 0; ad = 1;
      end
      if (wh) begin
        wvalid <= 0; wd = 1;
      end
    end
    bready <= 1;
    while (!bh) begin
      @(negedge clk);
      bh = bvalid;
      @(posedge clk);
    end
    bready <= 0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ah, rh;
    ah = 0; rh = 0;
    araddr <= a; arvalid <= 1;
    while (!ah) begin
      @(negedge clk);
      ah = arready;
      @(posedge clk);
    end
    arvalid <= 0; rready <= 1;
    while (!rh) begin
      @(negedge clk);
      rh = rvalid;
      d = rdata;
      @(posedge clk);
    end
    rready <= 0;
  endtask

  task automatic wait_irq();
    logic [31:0] s;
    s = 0;
    for (int i = 0; i < 300 && s[`IMR_STAT_IRQ] !== 1'b1; i++)
      rd(`IMR_OFF_STAT, s);
    check(s[`IMR_STAT_IRQ], 1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_start();
    logic [31:0] s;
    wr(`IMR_OFF_CTRL, 1 << `IMR_CTRL_SEN);
    wait_irq();
    rd(`IMR_OFF_CTRL, s);
    check(s, 0);
    wr(`IMR_OFF_STAT, 32'h2);
  endtask

  // A receive request during the address phase must be dropped.
  task automatic t_addr(input logic [7:0] a, input logic ack);
    logic [31:0] s;
    wr(`IMR_OFF_DATA, {24'h0, a});
    wr(`IMR_OFF_CTRL, 1 << `IMR_CTRL_MASTER_RECEIVE_REQUEST);
    wait_irq();
    check(got_addr, a);
    rd(`IMR_OFF_CTRL, s);
    check(s, ack << `IMR_CTRL_ACKST);
    rd(`IMR_OFF_STAT, s);
    check(s & 32'h12, 32'h12);
    wr(`IMR_OFF_STAT, 32'h2);
  endtask

  task automatic t_recv(input logic [7:0] b, input logic rdb,
                        input logic ov);
    logic [31:0] s;
    int e;
    wr(`IMR_OFF_CTRL, 1 << `IMR_CTRL_MASTER_RECEIVE_REQUEST);
    wr(`IMR_OFF_DATA, 32'h3C);
    wait_irq();
    rd(`IMR_OFF_STAT, s);
    check(s, 32'h1B | (ov << `IMR_STAT_OV));
    rd(`IMR_OFF_CTRL, s);
    check(s[`IMR_CTRL_MASTER_RECEIVE_REQUEST], 0);
    check(scl_oe, 1);
    check({scl_o, sda_o}, 0);
    e = edges;
    repeat (40) @(posedge clk);
    check(edges, e);
    wr(`IMR_OFF_STAT, 32'hE);
    if (rdb) begin
      rd(`IMR_OFF_DATA, s);
      check(s, b);
      rd(`IMR_OFF_STAT, s);
      check(s[`IMR_STAT_BF], 0);
    end
  endtask

  task automatic t_ack(input logic v);
    logic [31:0] s;
    wr(`IMR_OFF_CTRL,
       (v << `IMR_CTRL_ACK_VALUE_SELECT) | (1 << `IMR_CTRL_ACK_SEQUENCE_REQUEST));
    wait_irq();
    check(m_ack, v);
    rd(`IMR_OFF_CTRL, s);
    check(s[`IMR_CTRL_ACK_SEQUENCE_REQUEST], 0);
    wr(`IMR_OFF_STAT, 32'h2);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence.
  initial begin
    #(25 * 30000);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] s;
    repeat (3) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rd(`IMR_OFF_STAT, s);
    check(s, 1 << `IMR_STAT_IDLE);
    rd(`IMR_OFF_BAUD, s);
    check(s, `IMR_BAUD_RST);
    wr(`IMR_OFF_BAUD, 32'h1);
    t_start();
    t_addr(8'h55, 0);
    t_recv(8'hC5, 0, 0);
    t_ack(1);
    t_recv(8'hFF, 1, 1);
    t_start();
    t_addr(8'h55, 0);
    t_recv(8'hC5, 1, 0);
    t_ack(0);
    t_start();
    t_addr(8'h23, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
